// ---- rtl/cirf_top.sv ----
`timescale 1ns/1ps
`include "cirf_params.svh"
module cirf_top (
	input wire logic clock, // 20 MHz system clock
	input wire logic rst, // synchronous active-high reset
	input wire logic [3:0] reg_addr, // register word address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic tx_last_bit_sent, // pulse: last transmit bit out
	input wire logic rx_frame_end, // pulse: valid stream end seen
	input wire logic fifo_has_data, // FIFO holds received bytes
	input wire logic fifo_high_level_status, // FIFO high level status
	input wire logic fifo_low_level_status, // FIFO low level status
	input wire logic [7:0] error_status_register, // error status bits
	input wire logic timer_event, // pulse: timer request
	input wire logic cmd_finish, // pulse: running command done
	input wire logic [15:0] known_commands, // recognised code mask
	output logic [3:0] command_code, // current command code
	output logic irq_pin, // interrupt pin level
	output logic evt_irq // block event interrupt, level
);
	cirf_pkg::cirf_flags_t flags_reg;
	cirf_pkg::cirf_flags_t flags_next;
	cirf_pkg::cirf_flags_t hw_set;
	cirf_pkg::cirf_byte_t interrupt_enable_mask;
	cirf_pkg::cirf_byte_t receive_mode_setting;
	cirf_pkg::cirf_op_t sw_op;
	logic [2:0] evt_stat_reg;
	logic [2:0] evt_en_reg;
	logic [2:0] evt_set;
	logic terminated;
	logic hi_rise;
	logic lo_rise;
	logic rx_ok;
	logic wr_irq;

	cirf_cmd_track u_cmd (
		.clock(clock),
		.rst(rst),
		.host_wr(reg_wr && reg_addr == `CIRF_ADDR_CMD),
		.host_code(reg_wdata[3:0]),
		.known_mask(known_commands),
		.cmd_finish(cmd_finish),
		.code_reg(command_code),
		.terminated(terminated)
	);

	cirf_rise_det u_hi (
		.clock(clock),
		.rst(rst),
		.level_in(fifo_high_level_status),
		.rise(hi_rise)
	);

	cirf_rise_det u_lo (
		.clock(clock),
		.rst(rst),
		.level_in(fifo_low_level_status),
		.rise(lo_rise)
	);

	// Empty frames are dropped only when suppression is on
	assign rx_ok = rx_frame_end &&
		(!receive_mode_setting[`CIRF_BIT_SUPPRESS] || fifo_has_data);

	always_comb begin
		hw_set = '0;
		hw_set[`CIRF_BIT_TX] = tx_last_bit_sent;
		hw_set[`CIRF_BIT_RX] = rx_ok;
		hw_set[`CIRF_BIT_IDLE] = terminated;
		hw_set[`CIRF_BIT_HI] = hi_rise;
		hw_set[`CIRF_BIT_LO] = lo_rise;
		hw_set[`CIRF_BIT_ERR] = |error_status_register;
		hw_set[`CIRF_BIT_TIMER] = timer_event;
	end

	assign wr_irq = reg_wr && reg_addr == `CIRF_ADDR_IRQ;

	always_comb begin
		if (!wr_irq) begin
			sw_op = cirf_pkg::CIRF_OP_NONE;
		end else if (reg_wdata[`CIRF_BIT_SETSEL]) begin
			sw_op = cirf_pkg::CIRF_OP_SET;
		end else begin
			sw_op = cirf_pkg::CIRF_OP_CLEAR;
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_comb begin
		flags_next = flags_reg;
		unique case (sw_op)
			cirf_pkg::CIRF_OP_NONE: flags_next = flags_reg;
			cirf_pkg::CIRF_OP_SET: flags_next = flags_reg | reg_wdata[6:0];
			cirf_pkg::CIRF_OP_CLEAR: flags_next = flags_reg & ~reg_wdata[6:0];
		endcase
		flags_next = flags_next | hw_set;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			flags_reg <= `CIRF_IRQ_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			interrupt_enable_mask <= `CIRF_IEN_RESET;
			receive_mode_setting <= `CIRF_RXMODE_RESET;
			evt_en_reg <= '0;
		end else if (reg_wr) begin
			if (reg_addr == `CIRF_ADDR_IEN) begin
				interrupt_enable_mask <= reg_wdata;
			end
			if (reg_addr == `CIRF_ADDR_RXMODE) begin
				receive_mode_setting <= reg_wdata;
			end
			if (reg_addr == `CIRF_ADDR_EVT_EN) begin
				evt_en_reg <= reg_wdata[2:0];
			end
		end
	end

	// Block events: transmit done, receive done, command terminated
	assign evt_set = {tx_last_bit_sent, rx_ok, terminated};

	always_ff @(posedge clock) begin
		if (rst) begin
			evt_stat_reg <= '0;
		end else if (reg_wr && reg_addr == `CIRF_ADDR_EVT_CLR) begin
			evt_stat_reg <= (evt_stat_reg & ~reg_wdata[2:0]) | evt_set;
		end else begin
			evt_stat_reg <= evt_stat_reg | evt_set;
		end
	end

	// Pin follows registered flags, so it lags the flag by one cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_pin <= 1'(`CIRF_IEN_RESET >> `CIRF_BIT_INVERT);
			evt_irq <= 1'b0;
		end else begin
			irq_pin <= (|(flags_reg & interrupt_enable_mask[6:0])) ^
				interrupt_enable_mask[`CIRF_BIT_INVERT];
			evt_irq <= |(evt_stat_reg & evt_en_reg);
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`CIRF_ADDR_IRQ: reg_rdata <= {1'b0, flags_reg};
				`CIRF_ADDR_IEN: reg_rdata <= interrupt_enable_mask;
				`CIRF_ADDR_RXMODE: reg_rdata <= receive_mode_setting;
				`CIRF_ADDR_CMD: reg_rdata <= {4'h0, command_code};
				`CIRF_ADDR_EVT_STAT: reg_rdata <= {5'h00, evt_stat_reg};
				`CIRF_ADDR_EVT_EN: reg_rdata <= {5'h00, evt_en_reg};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule

// ---- rtl/cirf_params.svh ----
`ifndef CIRF_PARAMS_SVH
`define CIRF_PARAMS_SVH

// Register word addresses on the plain register port
`define CIRF_ADDR_W 4
`define CIRF_ADDR_IEN 4'h2
`define CIRF_ADDR_IRQ 4'h4
`define CIRF_ADDR_CMD 4'h1
`define CIRF_ADDR_RXMODE 4'h3
`define CIRF_ADDR_CTRL 4'h8
`define CIRF_ADDR_EVT_STAT 4'h9
`define CIRF_ADDR_EVT_CLR 4'ha
`define CIRF_ADDR_EVT_EN 4'hb

// Reset values
`define CIRF_IEN_RESET 8'h80
`define CIRF_IRQ_RESET 7'h14
`define CIRF_RXMODE_RESET 8'h00

// Field positions in the request, interrupt enable and receive mode registers
`define CIRF_BIT_SETSEL 7
`define CIRF_BIT_TX 6
`define CIRF_BIT_RX 5
`define CIRF_BIT_IDLE 4
`define CIRF_BIT_HI 3
`define CIRF_BIT_LO 2
`define CIRF_BIT_ERR 1
`define CIRF_BIT_TIMER 0
`define CIRF_BIT_INVERT 7
`define CIRF_BIT_SUPPRESS 3

// Command codes
`define CIRF_CMD_IDLE 4'h0
`define CIRF_CMD_W 4

`endif

// ---- rtl/cirf_pkg.sv ----
package cirf_pkg;
	typedef logic [7:0] cirf_byte_t;
	typedef logic [6:0] cirf_flags_t;
	typedef enum logic [1:0] {
		CIRF_OP_NONE,
		CIRF_OP_SET,
		CIRF_OP_CLEAR
	} cirf_op_t;
	typedef enum {
		CIRF_CMD_IDLE_ST,
		CIRF_CMD_RUN_ST
	} cirf_cmd_state_t;
endpackage

// ---- rtl/cirf_rise_det.sv ----
`timescale 1ns/1ps
// Rising-edge detector with a combinational output for a same-clock level
module cirf_rise_det (
	input wire logic clock, // system clock
	input wire logic rst, // synchronous reset
	input wire logic level_in, // level to watch
	output logic rise // one-cycle pulse on 0 to 1
);
	logic last_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			last_reg <= 1'b0;
		end else begin
			last_reg <= level_in;
		end
	end

	assign rise = level_in & ~last_reg;
endmodule

// ---- rtl/cirf_cmd_track.sv ----
`timescale 1ns/1ps
`include "cirf_params.svh"
// Holds the command code; detects termination and unknown codes
module cirf_cmd_track (
	input wire logic clock, // system clock
	input wire logic rst, // synchronous reset
	input wire logic host_wr, // host writes the command code
	input wire logic [3:0] host_code, // code written by host
	input wire logic [15:0] known_mask, // one bit per recognised code
	input wire logic cmd_finish, // running command ends itself
	output logic [3:0] code_reg, // current command code
	output logic terminated // pulse: command ended itself or unknown code written, none on host abort
);
	cirf_pkg::cirf_cmd_state_t state_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			code_reg <= `CIRF_CMD_IDLE;
			state_reg <= cirf_pkg::CIRF_CMD_IDLE_ST;
			terminated <= 1'b0;
		end else begin
			terminated <= 1'b0;
			unique case (state_reg)
				cirf_pkg::CIRF_CMD_IDLE_ST: begin
					if (host_wr && host_code != `CIRF_CMD_IDLE) begin
						if (known_mask[host_code]) begin
							code_reg <= host_code;
							state_reg <= cirf_pkg::CIRF_CMD_RUN_ST;
						end else begin
							// Unknown code falls straight back to idle
							code_reg <= `CIRF_CMD_IDLE;
							terminated <= 1'b1;
						end
					end
					// Host writing idle while idle raises nothing
				end
				cirf_pkg::CIRF_CMD_RUN_ST: begin
					if (host_wr && host_code == `CIRF_CMD_IDLE) begin
						// Host abort: code returns to idle without a flag
						code_reg <= `CIRF_CMD_IDLE;
						state_reg <= cirf_pkg::CIRF_CMD_IDLE_ST;
					end else if (host_wr && !known_mask[host_code]) begin
						code_reg <= `CIRF_CMD_IDLE;
						state_reg <= cirf_pkg::CIRF_CMD_IDLE_ST;
						terminated <= 1'b1;
					end else if (host_wr) begin
						code_reg <= host_code;
					end else if (cmd_finish) begin
						code_reg <= `CIRF_CMD_IDLE;
						state_reg <= cirf_pkg::CIRF_CMD_IDLE_ST;
						terminated <= 1'b1;
					end
				end
			endcase
		end
	end
endmodule

// ---- tb/cirf_checker.sv ----
`timescale 1ns/1ps
module cirf_checker (
	input wire logic clock, // clock
	input wire logic rst, // reset
	input wire logic [3:0] reg_addr, // address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_rdata, // read data
	input wire logic tx_last_bit_sent, // tx done
	input wire logic fifo_high_level_status, // high level
	input wire logic [7:0] error_status_register, // errors
	input wire logic cmd_finish, // command end
	input wire logic [15:0] known_commands, // code mask
	input wire logic [3:0] command_code, // code
	input wire logic irq_pin // pin
);
	logic [7:0] en_reg;
	logic [6:0] must_reg;
	logic [6:0] seen;
	logic rd_reg;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Mirror of the mask, so the pin checks know what is enabled
	always_ff @(posedge clock) begin
		if (rst) en_reg <= 8'h80;
		else if (reg_wr && reg_addr == 4'h2) en_reg <= reg_wdata;
	end
	always_ff @(posedge clock) begin
		if (rst) rd_reg <= 1'b0;
		else rd_reg <= reg_rd && reg_addr == 4'h4;
	end
	// Bits once read as set must read set until a clear write names them
	assign seen = rd_reg ? reg_rdata[6:0] : must_reg;
	always_ff @(posedge clock) begin
		if (rst) must_reg <= 7'h00;
		else if (reg_wr && reg_addr == 4'h4 && !reg_wdata[7]) must_reg <= seen & ~reg_wdata[6:0];
		else must_reg <= seen;
	end
	sequence s_tx_armed;
		tx_last_bit_sent && en_reg == 8'h40 ##1 en_reg == 8'h40;
	endsequence
	sequence s_err_armed;
		error_status_register != 8'h00 && en_reg == 8'h02 ##1 en_reg == 8'h02;
	endsequence
	a_read_sel_zero: assert property (rd_reg |-> !reg_rdata[7])
		else $error("selector bit read back");
	a_flags_sticky: assert property (rd_reg |-> (reg_rdata[6:0] & must_reg) == must_reg)
		else $error("flag lost without clear");
	a_unknown_cmd: assert property (reg_wr && reg_addr == 4'h1
		&& !known_commands[reg_wdata[3:0]] |=> command_code == 4'h0)
		else $error("unknown code kept");
	a_cmd_end: assert property (cmd_finish |-> ##[1:2] command_code == 4'h0)
		else $error("code not back to idle");
	a_pin_invert: assert property (en_reg[6:0] == 7'h00 |=> irq_pin == $past(en_reg[7]))
		else $error("pin level wrong with mask clear");
	a_tx_pin: assert property (s_tx_armed |=> irq_pin)
		else $error("tx done missed pin");
	a_high_alert: assert property ($rose(fifo_high_level_status) && en_reg == 8'h08
		|-> ##[1:4] irq_pin)
		else $error("high level rise missed");
	a_err_pin: assert property (s_err_armed |=> irq_pin)
		else $error("error missed pin");
endmodule
bind cirf_top cirf_checker i_cirf_checker (.clock(clock), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.tx_last_bit_sent(tx_last_bit_sent), .fifo_high_level_status(fifo_high_level_status),
	.error_status_register(error_status_register), .cmd_finish(cmd_finish),
	.known_commands(known_commands), .command_code(command_code), .irq_pin(irq_pin));

// ---- tb/cirf_top_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module cirf_top_tb;
	logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tx = 1'b0, rx = 1'b0;
	logic fifo = 1'b0, hi = 1'b0, lo = 1'b0, fin = 1'b0, pin, evt;
	logic [3:0] addr = 4'h0, code;
	logic [7:0] wdata = 8'h00, rdata, err = 8'h00;
	logic [15:0] known = 16'h0003;
	int errors = 0, comparisons = 0;
	cirf_top i_cirf_top (.clock(clock), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .tx_last_bit_sent(tx),
		.rx_frame_end(rx), .fifo_has_data(fifo), .fifo_high_level_status(hi),
		.fifo_low_level_status(lo), .error_status_register(err), .timer_event(1'b0),
		.cmd_finish(fin), .known_commands(known), .command_code(code), .irq_pin(pin),
		.evt_irq(evt));
	initial forever #25 clock = ~clock;
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 `CHK(rdata, e);
	endtask
	task automatic t_basic;
		rd(4'h4, 8'h14);
		`CHK(pin, 1'b1);
		rd(4'h8, 8'h00);
		wr(4'h4, 8'h7f);
		rd(4'h4, 8'h00);
		wr(4'h4, 8'hc0);
		rd(4'h4, 8'h40);
		wr(4'h4, 8'h80);
		rd(4'h4, 8'h40);
		wr(4'h4, 8'h40);
		rd(4'h4, 8'h00);
	endtask
	task automatic t_tx;
		wr(4'h2, 8'h40);
		wr(4'hb, 8'h04);
		@(posedge clock) tx <= 1'b1;
		@(posedge clock) tx <= 1'b0;
		@(posedge clock);
		#1 `CHK(pin, 1'b1);
		`CHK(evt, 1'b1);
		cyc(5);
		rd(4'h4, 8'h40);
		rd(4'h9, 8'h04);
		wr(4'ha, 8'h04);
		rd(4'h9, 8'h00);
		`CHK(evt, 1'b0);
		wr(4'h4, 8'h40);
		cyc(1);
		#1 `CHK(pin, 1'b0);
	endtask
	task automatic t_rx;
		wr(4'h3, 8'h08);
		@(posedge clock) rx <= 1'b1;
		@(posedge clock) rx <= 1'b0;
		rd(4'h4, 8'h00);
		@(posedge clock) fifo <= 1'b1;
		@(posedge clock) rx <= 1'b1;
		@(posedge clock) rx <= 1'b0;
		rd(4'h4, 8'h20);
		wr(4'h4, 8'h20);
		wr(4'h3, 8'h00);
		@(posedge clock) fifo <= 1'b0;
		@(posedge clock) rx <= 1'b1;
		@(posedge clock) rx <= 1'b0;
		rd(4'h4, 8'h20);
		wr(4'h4, 8'h20);
	endtask
	task automatic t_cmd;
		wr(4'h1, 8'h01);
		rd(4'h4, 8'h00);
		`CHK(code, 4'h1);
		@(posedge clock) fin <= 1'b1;
		@(posedge clock) fin <= 1'b0;
		cyc(3);
		`CHK(code, 4'h0);
		rd(4'h4, 8'h10);
		wr(4'h4, 8'h10);
		wr(4'h1, 8'h01);
		wr(4'h1, 8'h00);
		cyc(3);
		rd(4'h4, 8'h00);
		wr(4'h1, 8'h05);
		cyc(3);
		`CHK(code, 4'h0);
		rd(4'h4, 8'h10);
		wr(4'h4, 8'h10);
	endtask
	task automatic t_alert;
		wr(4'h2, 8'h08);
		@(posedge clock) hi <= 1'b1;
		cyc(4);
		#1 `CHK(pin, 1'b1);
		@(posedge clock) hi <= 1'b0;
		rd(4'h4, 8'h08);
		wr(4'h2, 8'h88);
		cyc(2);
		#1 `CHK(pin, 1'b0);
		wr(4'h4, 8'h08);
		@(posedge clock) lo <= 1'b1;
		cyc(3);
		lo <= 1'b0;
		rd(4'h4, 8'h04);
		wr(4'h4, 8'h04);
		wr(4'h2, 8'h02);
		@(posedge clock) err <= 8'h10;
		cyc(3);
		#1 `CHK(pin, 1'b1);
		@(posedge clock) err <= 8'h00;
		rd(4'h4, 8'h02);
		wr(4'h4, 8'h02);
		rd(4'h4, 8'h00);
	endtask
	task automatic give_verdict;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_basic;
		t_tx;
		t_rx;
		t_cmd;
		t_alert;
		give_verdict;
	end
	// Watchdog so a stuck sequence still reaches the verdict
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		give_verdict;
	end
endmodule
